// [dwbd_checker.sv]
// Wire-level checks of the write-burst link between controller and device.
// Assumes every link signal is sampled on the system clock of both ends.
`timescale 1ns/100ps
`default_nettype none
module dwbd_checker (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link signals.
  input wire logic ck,
  input wire logic cas_n,
  input wire logic ras_n,
  input wire logic we_n,
  input wire logic [dwbd_pkg::DQ_W-1:0] dq_ctl,
  input wire logic dq_ctl_oe,
  input wire logic dqs_ctl,
  input wire logic dqs_ctl_oe,
  input wire logic dqs_dev_oe,
  input wire logic [dwbd_pkg::MASK_W-1:0] mask
);
  logic [6:0] gap;
  logic [7:0] span;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Cycles since cas_n last fell (column or mode register set command), saturating.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) gap <= 7'h7F;
    else if ($fell(cas_n)) gap <= 7'h00;
    else if (gap != 7'h7F) gap <= gap + 7'h01;
  end
  // Length of the current strobe drive window.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) span <= 8'h00;
    else span <= dqs_ctl_oe ? span + 8'h01 : 8'h00;
  end
  property p_gap; $fell(cas_n) |-> gap >= 7'h3F; endproperty
  a_gap: assert property (p_gap) else $error("column commands too close");
  property p_lat; $fell(cas_n) && ras_n && !we_n |-> ##[72:264] $rose(dqs_ctl_oe); endproperty
  a_lat: assert property (p_lat) else $error("write strobe window late");
  property p_len; $fell(dqs_ctl_oe) |-> span == 8'h50 || span == 8'h30; endproperty
  a_len: assert property (p_len) else $error("burst window length wrong");
  property p_oe; dq_ctl_oe |-> dqs_ctl_oe; endproperty
  a_oe: assert property (p_oe) else $error("data driven without strobe");
  property p_pre; $rose(dqs_ctl_oe) |-> !dqs_ctl [*8]; endproperty
  a_pre: assert property (p_pre) else $error("strobe preamble missing");
  property p_rise; $rose(dqs_ctl) |-> $rose(ck); endproperty
  a_rise: assert property (p_rise) else $error("rising strobe off clock");
  property p_fall; $fell(dqs_ctl) |-> $fell(ck); endproperty
  a_fall: assert property (p_fall) else $error("falling strobe off clock");
  property p_hold; $changed(dqs_ctl) |-> dq_ctl == $past(dq_ctl, 3) && mask == $past(mask, 3); endproperty
  a_hold: assert property (p_hold) else $error("data or mask moved near strobe");
  property p_turn; $fell(dqs_ctl_oe) |-> !dqs_dev_oe [*8]; endproperty
  a_turn: assert property (p_turn) else $error("device drove strobe after write");
endmodule : dwbd_checker
`default_nettype wire

// [dwbd_ctrl.sv]
// Controller end: makes the link clock, issues one command at a time and runs its data burst.
// Assumes a plain register port on the same clock; the device answers reads edge-aligned.
`timescale 1ns/100ps
`default_nettype none
module dwbd_ctrl (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link to the device.
  dwbd_link_if.ctl link,
  // Register port.
  input wire logic [2:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  localparam int PH_W = $clog2(2 * dwbd_pkg::CK_HALF);
  localparam int T_W = 12;
  localparam logic [T_W-1:0] HALF = T_W'(dwbd_pkg::CK_HALF);

  typedef enum logic [1:0] {DWBD_IDLE, DWBD_ISSUE, DWBD_ARM, DWBD_XFER} dwbd_state_t;

  dwbd_state_t state;
  logic [PH_W-1:0] ph;
  logic [PH_W-1:0] next_ph;
  logic [T_W-1:0] tc;
  logic [T_W-1:0] tn;
  logic [1:0] op;
  logic burst_sel;
  logic [18:0] addr_reg;
  logic [63:0] wdata;
  logic [7:0] wmask;
  logic [63:0] rdata;
  logic rd_done;
  logic [dwbd_pkg::ADDR_W-1:0] sh_mr0;
  logic [dwbd_pkg::ADDR_W-1:0] sh_mr1;
  logic [dwbd_pkg::ADDR_W-1:0] sh_mr2;
  logic [3:0] dbeat;
  logic [3:0] sbeat;
  logic [3:0] rbeat;
  logic [1:0] dsync1;
  logic [1:0] dsync2;
  logic [dwbd_pkg::DQ_W-1:0] dqsync1;
  logic [dwbd_pkg::DQ_W-1:0] dqsync2;
  logic dqs_prev;
  logic [dwbd_pkg::LAT_W-1:0] lat;
  logic [3:0] len;
  logic [T_W-1:0] e0;
  logic [T_W-1:0] e_end;
  logic [T_W-1:0] t_done;
  logic [T_W-1:0] t_min;

  assign next_ph = (ph == PH_W'(2 * dwbd_pkg::CK_HALF - 1)) ? '0 : ph + PH_W'(1);
  assign tn = tc + T_W'(1);

  always_comb begin
    lat = (op == dwbd_pkg::OP_READ) ? dwbd_pkg::read_lat(sh_mr1) : dwbd_pkg::write_lat(sh_mr1, sh_mr2);
    len = dwbd_pkg::is_four(sh_mr0[dwbd_pkg::MR0_BL_LSB +: 2], burst_sel) ? 4'h4 : 4'h8;
    e0 = T_W'({lat, 1'b0}) * HALF;
    e_end = e0 + T_W'(len - 4'h1) * HALF;
    // Recovery counted from the first rising edge after the last beat.
    case (op)
      dwbd_pkg::OP_WRITE: t_done = e_end + HALF + T_W'(2 * dwbd_pkg::CK_HALF * dwbd_pkg::WR_CK);
      dwbd_pkg::OP_READ: t_done = e_end + T_W'(3) * HALF;
      default: t_done = '0;
    endcase
    t_min = T_W'(2 * dwbd_pkg::CK_HALF * dwbd_pkg::TCCD_CK);
    if (t_done < t_min) begin
      t_done = t_min;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph <= '0;
      link.ck <= 1'b0;
      dsync1 <= '0;
      dsync2 <= '0;
      dqsync1 <= '0;
      dqsync2 <= '0;
      dqs_prev <= 1'b0;
    end else begin
      ph <= next_ph;
      link.ck <= next_ph < PH_W'(dwbd_pkg::CK_HALF);
      dsync1 <= {link.dqs, link.term_strobe};
      dsync2 <= dsync1;
      dqsync1 <= link.dq;
      dqsync2 <= dqsync1;
      dqs_prev <= dsync2[1];
    end
  end

  // Register port: configuration writes, command start and read-back.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_reg <= '0;
      wdata <= '0;
      wmask <= '0;
      o_rdata <= '0;
    end else begin
      if (i_wr) begin
        case (i_addr)
          dwbd_pkg::REG_ADDR: addr_reg <= i_wdata[18:0];
          dwbd_pkg::REG_WDATA_LO: wdata[31:0] <= i_wdata;
          dwbd_pkg::REG_WDATA_HI: wdata[63:32] <= i_wdata;
          dwbd_pkg::REG_MASK: wmask <= i_wdata[7:0];
          default: wmask <= wmask;
        endcase
      end
      if (i_rd) begin
        case (i_addr)
          dwbd_pkg::REG_ADDR: o_rdata <= {13'h0000, addr_reg};
          dwbd_pkg::REG_WDATA_LO: o_rdata <= wdata[31:0];
          dwbd_pkg::REG_WDATA_HI: o_rdata <= wdata[63:32];
          dwbd_pkg::REG_MASK: o_rdata <= {24'h000000, wmask};
          dwbd_pkg::REG_RDATA_LO: o_rdata <= rdata[31:0];
          dwbd_pkg::REG_RDATA_HI: o_rdata <= rdata[63:32];
          // Bit two shows the device's termination strobe as it is seen now.
          dwbd_pkg::REG_STATUS: o_rdata <= {29'h00000000, dsync2[0], rd_done, state != DWBD_IDLE};
          default: o_rdata <= '0;
        endcase
      end
    end
  end

  // Command sequencing: drive at a falling edge, the device takes it at the next rising one.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= DWBD_IDLE;
      op <= '0;
      burst_sel <= 1'b0;
      tc <= '0;
      rd_done <= 1'b0;
      sh_mr0 <= dwbd_pkg::MR0_RST;
      sh_mr1 <= dwbd_pkg::MR1_RST;
      sh_mr2 <= dwbd_pkg::MR2_RST;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dwbd_pkg::CMD_NOP;
      link.ba <= '0;
      link.addr <= '0;
    end else begin
      tc <= tn;
      case (state)
        DWBD_IDLE: begin
          if (i_wr && i_addr == dwbd_pkg::REG_CMD && i_wdata[1:0] != 2'h0) begin
            op <= i_wdata[1:0];
            burst_sel <= i_wdata[dwbd_pkg::CMD_BURST_BIT];
            rd_done <= 1'b0;
            state <= DWBD_ISSUE;
          end
        end
        DWBD_ISSUE: begin
          if (next_ph == PH_W'(dwbd_pkg::CK_HALF)) begin
            link.ba <= addr_reg[dwbd_pkg::ADDR_BA_LSB +: dwbd_pkg::BA_W];
            link.addr <= addr_reg[dwbd_pkg::ADDR_W-1:0];
            case (op)
              dwbd_pkg::OP_WRITE: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dwbd_pkg::CMD_WRITE;
              dwbd_pkg::OP_READ: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dwbd_pkg::CMD_READ;
              default: {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dwbd_pkg::CMD_MRS;
            endcase
            if (op != dwbd_pkg::OP_MODE) begin
              // Burst selector on address bit twelve.
              link.addr[dwbd_pkg::A_BURST_SEL] <= burst_sel;
            end else begin
              case (addr_reg[dwbd_pkg::ADDR_BA_LSB +: dwbd_pkg::BA_W])
                3'h0: sh_mr0 <= addr_reg[dwbd_pkg::ADDR_W-1:0];
                3'h1: sh_mr1 <= addr_reg[dwbd_pkg::ADDR_W-1:0];
                3'h2: sh_mr2 <= addr_reg[dwbd_pkg::ADDR_W-1:0];
                default: sh_mr0 <= sh_mr0;
              endcase
            end
            state <= DWBD_ARM;
          end
        end
        DWBD_ARM: begin
          if (next_ph == '0) begin
            tc <= '0;
            state <= DWBD_XFER;
          end
        end
        DWBD_XFER: begin
          if (tn == HALF) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dwbd_pkg::CMD_NOP;
          end
          if (tn == t_done) begin
            rd_done <= rd_done | (op == dwbd_pkg::OP_READ);
            state <= DWBD_IDLE;
          end
        end
        default: state <= DWBD_IDLE;
      endcase
    end
  end

  // Write data moves a quarter clock before each strobe edge; read beats are caught on strobe edges.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dbeat <= '0;
      sbeat <= '0;
      rbeat <= '0;
      rdata <= '0;
      link.dq_ctl <= '0;
      link.dq_ctl_oe <= 1'b0;
      link.dqs_ctl <= 1'b0;
      link.dqs_ctl_oe <= 1'b0;
      link.mask <= '0;
    end else if (state != DWBD_XFER) begin
      dbeat <= '0;
      sbeat <= '0;
      rbeat <= '0;
      link.dq_ctl_oe <= 1'b0;
      link.dqs_ctl_oe <= 1'b0;
      link.dqs_ctl <= 1'b0;
    end else if (op == dwbd_pkg::OP_WRITE) begin
      // Preamble one clock, postamble half a clock.
      link.dqs_ctl_oe <= tn + T_W'(2) * HALF >= e0 && tn < e_end + HALF;
      link.dq_ctl_oe <= tn + HALF / T_W'(2) >= e0 && tn < e_end + HALF / T_W'(2);
      if (dbeat < len && tn + HALF / T_W'(2) == e0 + T_W'(dbeat) * HALF) begin
        link.dq_ctl <= wdata[8 * dbeat[2:0] +: 8];
        link.mask <= wmask[dbeat[2:0]];
        dbeat <= dbeat + 4'h1;
      end
      // Strobe edges on the clock edges of the burst.
      if (sbeat < len && tn == e0 + T_W'(sbeat) * HALF) begin
        link.dqs_ctl <= ~sbeat[0];
        sbeat <= sbeat + 4'h1;
      end
    end else if (op == dwbd_pkg::OP_READ && rbeat < len && (dsync2[1] ^ dqs_prev)) begin
      rdata[8 * rbeat[2:0] +: 8] <= dqsync2;
      rbeat <= rbeat + 4'h1;
    end
  end
endmodule : dwbd_ctrl
`default_nettype wire

// [dwbd_device.sv]
// Memory device end: command decode, mode registers, write burst capture and read-back.
// Assumes the link clock, strobe and data come from another domain; all are synchronised
// together, so a strobe edge that coincides with a link clock edge is seen in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module dwbd_device #(
  parameter int SLOTS = 4
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link to the controller.
  dwbd_link_if.dev link,
  // Observation of the device.
  output logic o_write_beat,
  output logic [dwbd_pkg::COL_W-1:0] o_beat_col,
  output logic o_term_enable,
  output logic [dwbd_pkg::LAT_W-1:0] o_write_latency
);
  localparam int IN_W = 2 + dwbd_pkg::MASK_W + dwbd_pkg::DQ_W + 4 + dwbd_pkg::BA_W + dwbd_pkg::ADDR_W;
  localparam int IDX_W = $clog2(SLOTS);
  localparam int AGE_W = 7;

  logic [IN_W-1:0] in_raw;
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  logic s_ck;
  logic s_dqs;
  logic [dwbd_pkg::MASK_W-1:0] s_mask;
  logic [dwbd_pkg::DQ_W-1:0] s_dq;
  logic [3:0] s_cmd;
  logic [dwbd_pkg::BA_W-1:0] s_ba;
  logic [dwbd_pkg::ADDR_W-1:0] s_addr;
  logic ck_prev;
  logic dqs_prev;
  logic ck_rise;
  logic ck_edge;
  logic dqs_edge;

  logic [dwbd_pkg::ADDR_W-1:0] mr0;
  logic [dwbd_pkg::ADDR_W-1:0] mr1;
  logic [dwbd_pkg::ADDR_W-1:0] mr2;
  logic term_en;
  logic col_cmd;

  logic slot_vld [SLOTS];
  logic slot_wr [SLOTS];
  logic slot_four [SLOTS];
  logic [dwbd_pkg::COL_W-1:0] slot_col [SLOTS];
  logic [AGE_W-1:0] slot_age [SLOTS];
  logic [AGE_W-1:0] slot_start [SLOTS];
  logic [AGE_W-1:0] next_age [SLOTS];

  logic free_ok;
  logic [IDX_W-1:0] free_idx;
  logic act_hit;
  logic act_wr;
  logic [2:0] act_k;
  logic [dwbd_pkg::COL_W-1:0] act_col;
  logic rd_window;
  logic wr_window;
  logic beat_store;

  logic [dwbd_pkg::DQ_W-1:0] mem [2**dwbd_pkg::COL_W];

  function automatic logic [AGE_W-1:0] beats(input logic four);
    return four ? AGE_W'(4) : AGE_W'(8);
  endfunction : beats

  // Every link input, the clock among them, passes the same two flip-flops.
  assign in_raw = {link.ck, link.dqs, link.mask, link.dq, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                   link.ba, link.addr};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      ck_prev <= 1'b0;
      dqs_prev <= 1'b0;
    end else begin
      sync1 <= in_raw;
      sync2 <= sync1;
      ck_prev <= s_ck;
      dqs_prev <= s_dqs;
    end
  end

  assign {s_ck, s_dqs, s_mask, s_dq, s_cmd, s_ba, s_addr} = sync2;
  assign ck_rise = s_ck & ~ck_prev;
  assign ck_edge = s_ck ^ ck_prev;
  assign dqs_edge = s_dqs ^ dqs_prev;
  assign col_cmd = ck_rise && (s_cmd == dwbd_pkg::CMD_WRITE || s_cmd == dwbd_pkg::CMD_READ);
  assign term_en = mr1[dwbd_pkg::MR1_TERM_BIT];

  // Mode register set picks the register from the bank address.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mr0 <= dwbd_pkg::MR0_RST;
      mr1 <= dwbd_pkg::MR1_RST;
      mr2 <= dwbd_pkg::MR2_RST;
    end else if (ck_rise && s_cmd == dwbd_pkg::CMD_MRS) begin
      case (s_ba)
        3'h0: mr0 <= s_addr;
        3'h1: mr1 <= s_addr;
        3'h2: mr2 <= s_addr;
        default: mr0 <= mr0;
      endcase
    end
  end

  always_comb begin
    for (int s = 0; s < SLOTS; s++) begin
      next_age[s] = slot_age[s] + AGE_W'(1);
    end
  end

  // Find the slot whose beat falls on this link clock edge, and a free slot.
  always_comb begin
    free_ok = 1'b0;
    free_idx = '0;
    act_hit = 1'b0;
    act_wr = 1'b0;
    act_k = '0;
    act_col = '0;
    rd_window = 1'b0;
    wr_window = 1'b0;
    for (int s = 0; s < SLOTS; s++) begin
      if (slot_vld[s]) begin
        if (next_age[s] >= slot_start[s] && next_age[s] < slot_start[s] + beats(slot_four[s])) begin
          act_hit = 1'b1;
          act_wr = slot_wr[s];
          act_k = 3'(next_age[s] - slot_start[s]);
          act_col = dwbd_pkg::beat_col(slot_col[s], 3'(next_age[s] - slot_start[s]), slot_four[s]);
        end
        if (next_age[s] + AGE_W'(2) >= slot_start[s] && next_age[s] <= slot_start[s] + beats(slot_four[s])) begin
          rd_window = rd_window | ~slot_wr[s];
          wr_window = wr_window | slot_wr[s];
        end
      end else if (!free_ok) begin
        free_ok = 1'b1;
        free_idx = IDX_W'(s);
      end
    end
  end

  // Burst slots age by one on every link clock edge, rising or falling.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int s = 0; s < SLOTS; s++) begin
        slot_vld[s] <= 1'b0;
        slot_wr[s] <= 1'b0;
        slot_four[s] <= 1'b0;
        slot_col[s] <= '0;
        slot_age[s] <= '0;
        slot_start[s] <= '0;
      end
    end else begin
      if (ck_edge) begin
        for (int s = 0; s < SLOTS; s++) begin
          if (slot_vld[s]) begin
            slot_age[s] <= next_age[s];
            if (next_age[s] == slot_start[s] + beats(slot_four[s])) begin
              slot_vld[s] <= 1'b0;
            end
          end
        end
      end
      if (col_cmd && free_ok) begin
        slot_vld[free_idx] <= 1'b1;
        slot_wr[free_idx] <= s_cmd == dwbd_pkg::CMD_WRITE;
        slot_age[free_idx] <= '0;
        slot_col[free_idx] <= s_addr[dwbd_pkg::COL_W-1:0];
        slot_four[free_idx] <= dwbd_pkg::is_four(mr0[dwbd_pkg::MR0_BL_LSB +: 2], s_addr[dwbd_pkg::A_BURST_SEL]);
        if (s_cmd == dwbd_pkg::CMD_WRITE) begin
          slot_start[free_idx] <= {1'b0, dwbd_pkg::write_lat(mr1, mr2)} << 1;
        end else begin
          slot_start[free_idx] <= {1'b0, dwbd_pkg::read_lat(mr1)} << 1;
        end
      end
    end
  end

  // A beat is stored only when its strobe edge lands on its own clock edge.
  assign beat_store = ck_edge && act_hit && act_wr && dqs_edge && (term_en || !s_mask[0]);

  always_ff @(posedge i_clk) begin
    if (beat_store) begin
      mem[act_col] <= s_dq;
    end
  end

  // Read bursts drive data and strobe edge-aligned with the link clock.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.dq_dev <= '0;
      link.dq_dev_oe <= 1'b0;
      link.dqs_dev <= 1'b0;
      link.dqs_dev_oe <= 1'b0;
    end else if (ck_edge) begin
      link.dq_dev_oe <= act_hit && !act_wr;
      link.dqs_dev_oe <= rd_window;
      link.dqs_dev <= act_hit && !act_wr && !act_k[0];
      if (act_hit && !act_wr) begin
        link.dq_dev <= mem[act_col];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.term_strobe <= 1'b0;
      o_write_beat <= 1'b0;
      o_beat_col <= '0;
      o_term_enable <= 1'b0;
      o_write_latency <= '0;
    end else begin
      link.term_strobe <= term_en && wr_window;
      o_write_beat <= beat_store;
      if (beat_store) begin
        o_beat_col <= act_col;
      end
      o_term_enable <= term_en;
      o_write_latency <= dwbd_pkg::write_lat(mr1, mr2);
    end
  end
endmodule : dwbd_device
`default_nettype wire

// [dwbd_link_if.sv]
// Link between the memory device and its controller, with resolved two-way data and strobe.
// Assumes at most one side enables a two-way pin at a time; an undriven wire reads low.
`timescale 1ns/100ps
`default_nettype none
interface dwbd_link_if;
  logic ck;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [dwbd_pkg::BA_W-1:0] ba;
  logic [dwbd_pkg::ADDR_W-1:0] addr;
  logic [dwbd_pkg::MASK_W-1:0] mask;
  logic term_strobe;
  logic [dwbd_pkg::DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [dwbd_pkg::DQ_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic dqs_ctl;
  logic dqs_ctl_oe;
  logic dqs_dev;
  logic dqs_dev_oe;
  logic [dwbd_pkg::DQ_W-1:0] dq;
  logic dqs;

  assign dq = dq_ctl_oe ? dq_ctl : (dq_dev_oe ? dq_dev : '0);
  assign dqs = dqs_ctl_oe ? dqs_ctl : (dqs_dev_oe ? dqs_dev : 1'b0);

  modport dev (
    input ck, cs_n, ras_n, cas_n, we_n, ba, addr, mask, dq, dqs,
    output term_strobe, dq_dev, dq_dev_oe, dqs_dev, dqs_dev_oe
  );
  modport ctl (
    output ck, cs_n, ras_n, cas_n, we_n, ba, addr, mask, dq_ctl, dq_ctl_oe, dqs_ctl, dqs_ctl_oe,
    input term_strobe, dq, dqs
  );
endinterface : dwbd_link_if
`default_nettype wire

// [dwbd_pkg.sv]
// Constants, encodings and helper functions shared by both ends of the write-burst link.
// Assumes both ends run from one 100 MHz clock and that the controller makes the link clock.
`default_nettype none
package dwbd_pkg;
  // Clock and link timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CK_PERIOD_NS = 160;
  localparam int CK_HALF = CK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int TCCD_CK = 4;
  localparam int WTR_CK = 4;
  localparam int WR_CK = 8;
  localparam int CAS_LAT = 6;
  localparam int CWL_BASE = 5;
  // Widths.
  localparam int DQ_W = 8;
  localparam int MASK_W = DQ_W / 8;
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int COL_W = 6;
  localparam int LAT_W = 6;
  // Command encodings as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_MRS = 4'h0;
  // Address and mode register fields.
  localparam int A_BURST_SEL = 12;
  localparam int MR0_BL_LSB = 0;
  localparam int MR1_AL_LSB = 3;
  localparam int MR1_TERM_BIT = 11;
  localparam int MR2_CWL_LSB = 3;
  localparam logic [ADDR_W-1:0] MR0_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] MR1_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] MR2_RST = 14'h0000;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  // Controller register indexes and fields.
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA_LO = 3'h2;
  localparam logic [2:0] REG_WDATA_HI = 3'h3;
  localparam logic [2:0] REG_MASK = 3'h4;
  localparam logic [2:0] REG_RDATA_LO = 3'h5;
  localparam logic [2:0] REG_RDATA_HI = 3'h6;
  localparam logic [2:0] REG_STATUS = 3'h7;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_MODE = 2'h3;
  localparam int CMD_BURST_BIT = 2;
  localparam int ADDR_BA_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDONE_BIT = 1;

  // Chopped burst when the field is fixed-four, or on-the-fly with the selector low.
  function automatic logic is_four(input logic [1:0] bl, input logic sel);
    case (bl)
      BL_OTF: return ~sel;
      BL_FIXED4: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_four

  function automatic logic [LAT_W-1:0] add_lat(input logic [1:0] f);
    case (f)
      2'h1: return LAT_W'(CAS_LAT - 1);
      2'h2: return LAT_W'(CAS_LAT - 2);
      default: return '0;
    endcase
  endfunction : add_lat

  function automatic logic [LAT_W-1:0] write_lat(input logic [ADDR_W-1:0] mr1, input logic [ADDR_W-1:0] mr2);
    return add_lat(mr1[MR1_AL_LSB +: 2]) + LAT_W'(CWL_BASE) + LAT_W'(mr2[MR2_CWL_LSB +: 3]);
  endfunction : write_lat

  function automatic logic [LAT_W-1:0] read_lat(input logic [ADDR_W-1:0] mr1);
    return add_lat(mr1[MR1_AL_LSB +: 2]) + LAT_W'(CAS_LAT);
  endfunction : read_lat

  // Sequential beat order, wrapping inside four or eight columns.
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] col, input logic [2:0] k,
                                                input logic four);
    logic [2:0] low;
    low = four ? {col[2], col[1:0] + k[1:0]} : col[2:0] + k;
    return {col[COL_W-1:3], low};
  endfunction : beat_col
endpackage : dwbd_pkg
`default_nettype wire

// [dwbd_tb.sv]
// Bench joining the device and controller ends through one link.
// Assumes the controller register port and mode registers reset to zero.
`timescale 1ns/100ps
`default_nettype none
module dwbd_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic o_write_beat;
  logic [dwbd_pkg::COL_W-1:0] o_beat_col;
  logic o_term_enable;
  logic [dwbd_pkg::LAT_W-1:0] o_write_latency;
  logic [31:0] v;
  int fail_count = 0;
  int num_checks = 0;
  int beat_cnt = 0;
  int term_cnt = 0;
  dwbd_link_if link ();
  always #5 i_clk = ~i_clk;
  // Counts stored write beats and cycles with the termination strobe high.
  always @(posedge i_clk) begin
    if (o_write_beat === 1'b1) beat_cnt++;
    if (link.term_strobe === 1'b1) term_cnt++;
  end
  dwbd_device dwbd_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .o_write_beat(o_write_beat),
    .o_beat_col(o_beat_col), .o_term_enable(o_term_enable), .o_write_latency(o_write_latency));
  dwbd_ctrl dwbd_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  dwbd_checker dwbd_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .ck(link.ck), .cas_n(link.cas_n),
    .ras_n(link.ras_n), .we_n(link.we_n), .dq_ctl(link.dq_ctl), .dq_ctl_oe(link.dq_ctl_oe), .dqs_ctl(link.dqs_ctl),
    .dqs_ctl_oe(link.dqs_ctl_oe), .dqs_dev_oe(link.dqs_dev_oe), .mask(link.mask));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    @(posedge i_clk);
  endtask : rd
  // Issues one command and polls until the controller is idle again.
  task automatic op(input logic [31:0] a, input logic [31:0] c);
    wr(dwbd_pkg::REG_ADDR, a);
    wr(dwbd_pkg::REG_CMD, c);
    v = 32'h1;
    for (int n = 0; n < 1000 && v[0] !== 1'b0; n++) rd(dwbd_pkg::REG_STATUS);
    chk({31'h0, v[0]}, 32'h0);
  endtask : op
  task automatic ms(input logic [2:0] b, input logic [13:0] d);
    op({13'h0, b, 2'h0, d}, 32'h3);
  endtask : ms
  task automatic wb(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi, input logic [7:0] m,
                    input logic s);
    wr(dwbd_pkg::REG_WDATA_LO, lo);
    wr(dwbd_pkg::REG_WDATA_HI, hi);
    wr(dwbd_pkg::REG_MASK, {24'h0, m});
    op(a, {29'h0, s, dwbd_pkg::OP_WRITE});
  endtask : wb
  task automatic rb(input logic [31:0] a, input logic s, input logic [31:0] lo, input logic [31:0] hi);
    op(a, {29'h0, s, dwbd_pkg::OP_READ});
    rd(dwbd_pkg::REG_RDATA_LO);
    chk(v, lo);
    rd(dwbd_pkg::REG_RDATA_HI);
    chk(v, hi);
  endtask : rb
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    #300000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    wb(32'hA, 32'h03020100, 32'h07060504, 8'h00, 1'b0);
    chk({26'h0, o_beat_col}, 32'h9);
    rb(32'hA, 1'b0, 32'h03020100, 32'h07060504);
    wb(32'hA, 32'hA0A1A2A3, 32'hB0B1B2B3, 8'h0F, 1'b1);
    chk(32'(beat_cnt), 32'hC);
    rb(32'hA, 1'b1, 32'h03020100, 32'hB0B1B2B3);
    ms(3'h0, 14'h0001);
    wb(32'h10, 32'h11111111, 32'h22222222, 8'h00, 1'b1);
    wb(32'h410, 32'h33333333, 32'h44444444, 8'h00, 1'b0);
    rb(32'h10, 1'b1, 32'h33333333, 32'h22222222);
    wb(32'h18, 32'h77777777, 32'h88888888, 8'h00, 1'b1);
    ms(3'h0, 14'h0002);
    wb(32'h18, 32'h55555555, 32'h66666666, 8'h00, 1'b1);
    chk(32'(beat_cnt), 32'h24);
    rb(32'h18, 1'b1, 32'h55555555, 32'h22222222);
    ms(3'h0, 14'h0000);
    rb(32'h18, 1'b0, 32'h55555555, 32'h88888888);
    ms(3'h1, 14'h0808);
    chk({31'h0, o_term_enable}, 32'h1);
    chk({26'h0, o_write_latency}, 32'hA);
    chk(32'(term_cnt), 32'h0);
    wb(32'h18, 32'h99999999, 32'hAAAAAAAA, 8'hFF, 1'b1);
    chk(32'(beat_cnt), 32'h2C);
    chk({31'h0, term_cnt != 0}, 32'h1);
    rb(32'h18, 1'b1, 32'h99999999, 32'hAAAAAAAA);
    // A second reset in mid-run must bring both ends back to their defaults.
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk({31'h0, o_term_enable}, 32'h0);
    chk({26'h0, o_write_latency}, 32'h5);
    wb(32'h18, 32'hC3C2C1C0, 32'hC7C6C5C4, 8'h80, 1'b1);
    chk(32'(beat_cnt), 32'h33);
    rb(32'h18, 1'b1, 32'hC3C2C1C0, 32'hAAC6C5C4);
    finish_test();
  end
endmodule : dwbd_tb
`default_nettype wire
